// file: dv/accel_i2c_target_port_checker.sv
// concurrent checks on the two bus lines of the target port
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
module accel_i2c_target_port_checker (
  input  wire logic MCLK_I,
  input  wire logic RST_N_I,
  input  wire logic ctl_scl_oe,
  input  wire logic ctl_sda_oe,
  input  wire logic dev_scl_oe,
  input  wire logic dev_sda_oe,
  input  wire logic scl,
  input  wire logic sda
);
  // 1 us of stretching plus sampling slack across the two clocks
  localparam int STR_MAX = 113;

  logic       scl_q;
  logic       sda_q;
  logic       busy_q;
  logic       busy_d;
  logic       start_c;
  logic       stop_c;
  logic [7:0] str_q;
  logic [7:0] str_d;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  always_comb begin
    start_c = scl && scl_q && sda_q && !sda;
    stop_c  = scl && scl_q && !sda_q && sda;
    busy_d  = busy_q;
    if (start_c) begin
      busy_d = 1'h1;
    end else if (stop_c) begin
      busy_d = 1'h0;
    end
    str_d = 8'h00;
    if (dev_scl_oe) begin
      str_d = (str_q == 8'hFF) ? str_q : str_q + 8'h01;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_q  <= 1'h1;
      sda_q  <= 1'h1;
      busy_q <= 1'h0;
      str_q  <= 8'h00;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      busy_q <= busy_d;
      str_q  <= str_d;
    end
  end

  a_stretch_max: assert property (str_q <= STR_MAX)
    else $error("clock held low by target too long");
  a_dev_no_start: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("target pulled data low while clock high");
  a_ack_steady: assert property (
    (scl && $past(scl)) |-> $stable(dev_sda_oe))
    else $error("target data drive changed during clock high");
  a_stretch_late: assert property ($rose(dev_scl_oe) |-> $past(ctl_scl_oe))
    else $error("target stretch began while clock not held low");
  a_high_phase: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase cut short");
  a_one_sender: assert property (scl |-> !(ctl_sda_oe && dev_sda_oe))
    else $error("both parties drive data during clock high");
  a_stop_free: assert property (
    stop_c |-> (!ctl_scl_oe && !ctl_sda_oe)[*8])
    else $error("controller drove a line right after stop");
  a_idle_quiet: assert property (
    (!busy_q && !start_c) |-> !dev_sda_oe && !dev_scl_oe)
    else $error("target drove a line while bus free");
endmodule

// file: dv/accel_i2c_target_port_tb.sv
// bench: controller end and target end joined by the link interface
// assumes a register array model behind the target's register side
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  failures++; $display("[ERR] %s expected %h seen %h", nm, exp, got); \
  end end
module accel_i2c_target_port_tb;
  import i2c_tgt_pkg::*;
  logic        mclk;
  logic        link_clk;
  logic        rst_n;
  logic        strap;
  logic        cmd_valid;
  op_type      cmd_op;
  logic [7:0]  cmd_data;
  logic        cmd_ack;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rsp_ack;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [7:0]  rdata;
  logic        busy;
  logic [7:0]  mem [256];
  logic [15:0] wq [$];
  logic [15:0] ew [3] = '{16'hFE11, 16'hFF22, 16'h0033};
  int          failures;
  int          compares;

  i2c_link_if link ();
  i2c_bus_ctl i_i2c_bus_ctl (.MCLK_I(mclk), .RST_N_I(rst_n), .link(link),
    .CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op), .CMD_DATA_I(cmd_data),
    .CMD_ACK_I(cmd_ack), .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid),
    .RSP_DATA_O(rsp_data), .RSP_ACK_O(rsp_ack));
  i2c_tgt_dev i_i2c_tgt_dev (.MCLK_I(mclk), .LINK_CLK_I(link_clk),
    .RST_N_I(rst_n), .link(link), .ADDR_SELECT_STRAP_I(strap),
    .RDATA_I(rdata), .WR_STB_O(wr_stb), .WR_ADDR_O(wr_addr),
    .WR_DATA_O(wr_data), .RD_STB_O(rd_stb), .RD_ADDR_O(rd_addr),
    .BUSY_O(busy));
  accel_i2c_target_port_checker i_accel_i2c_target_port_checker (
    .MCLK_I(mclk), .RST_N_I(rst_n), .ctl_scl_oe(link.ctl_scl_oe),
    .ctl_sda_oe(link.ctl_sda_oe), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

  always #5 mclk = ~mclk;
  always #32 link_clk = ~link_clk;

  // register array behind the target; read data follows the address
  assign rdata = mem[rd_addr];
  always @(posedge mclk) begin
    if (wr_stb === 1'h1) begin
      mem[wr_addr] <= wr_data;
      wq.push_back({wr_addr, wr_data});
    end
  end

  task automatic final_report;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one command: wait ready, hold valid to the take edge, wait response (ready after stop, no wait after start)
  task automatic cmd(input op_type op, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    while (cmd_ready !== 1'h1 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    `CHK("cmd ready", 1'h1, n < 9000)
    cmd_valid <= 1'h1;
    cmd_op    <= op;
    cmd_data  <= d;
    cmd_ack   <= a;
    @(posedge mclk);
    cmd_valid <= 1'h0;
    n = 0;
    if (op != OP_START) begin
      do begin
        @(posedge mclk);
        n++;
      end while ((op == OP_STOP ? cmd_ready : rsp_valid) !== 1'h1 &&
                 n < 9000);
    end
    `CHK("cmd done", 1'h1, n < 9000)
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] d, input logic ea, input string nm);
    cmd(OP_WRITE, d, 1'h0);
    `CHK(nm, ea, rsp_ack)
    `CHK("echo", d, rsp_data)
  endtask

  task automatic rd(input logic a, input logic [7:0] ed, input string nm);
    cmd(OP_READ, 8'h00, a);
    `CHK(nm, ed, rsp_data)
  endtask

  task automatic sel(input logic [7:0] aw, input logic [7:0] ptr);
    cmd(OP_START, 8'h00, 1'h0);
    wr(aw, 1'h1, "addr ack");
    wr(ptr, 1'h1, "ptr ack");
  endtask

  initial begin
    mclk = 1'h0;
    link_clk = 1'h0;
    rst_n = 1'h0;
    strap = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'h0;
    failures = 0;
    compares = 0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    repeat (3) @(posedge link_clk);
    @(posedge mclk);
    rst_n <= 1'h1;
    repeat (40) @(posedge mclk);
    // burst write across the pointer wrap
    sel(8'h30, 8'hFE);
    `CHK("busy", 1'h1, busy)
    wr(8'h11, 1'h1, "wd0");
    wr(8'h22, 1'h1, "wd1");
    wr(8'h33, 1'h1, "wd2");
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (100) @(posedge mclk);
    `CHK("busy", 1'h0, busy)
    `CHK("nwr", 3, wq.size())
    for (int i = 0; i < 3 && i < wq.size(); i++) begin
      `CHK("wq", ew[i], wq[i])
    end
    wq.delete();
    // burst read after repeated start, ended by nack
    sel(8'h30, 8'hFE);
    cmd(OP_START, 8'h00, 1'h0);
    `CHK("busy rs", 1'h1, busy)
    wr(8'h31, 1'h1, "addr rd");
    rd(1'h1, 8'h11, "rd0");
    rd(1'h1, 8'h22, "rd1");
    rd(1'h1, 8'h33, "rd2");
    rd(1'h0, 8'h01 ^ 8'hA5, "rd3");
    cmd(OP_STOP, 8'h00, 1'h0);
    // foreign address is ignored
    cmd(OP_START, 8'h00, 1'h0);
    wr(8'h32, 1'h0, "mis");
    wr(8'h55, 1'h0, "ign");
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (100) @(posedge mclk);
    `CHK("nwr mis", 0, wq.size())
    // strap high selects the other address
    strap <= 1'h1;
    repeat (50) @(posedge mclk);
    cmd(OP_START, 8'h00, 1'h0);
    wr(8'h30, 1'h0, "old");
    sel(8'h32, 8'h40);
    wr(8'h99, 1'h1, "wd hi");
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (100) @(posedge mclk);
    `CHK("nwr hi", 1, wq.size())
    if (wq.size() > 0) begin
      `CHK("wq hi", 16'h4099, wq[0])
    end
    sel(8'h32, 8'h40);
    cmd(OP_START, 8'h00, 1'h0);
    wr(8'h33, 1'h1, "addr rd hi");
    rd(1'h0, 8'h99, "rd hi");
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (50) @(posedge mclk);
    // reset mid-run, then read with no pointer set: fetch stretches
    rst_n <= 1'h0;
    repeat (3) @(posedge link_clk);
    @(posedge mclk);
    rst_n <= 1'h1;
    repeat (40) @(posedge mclk);
    `CHK("busy rst", 1'h0, busy)
    cmd(OP_START, 8'h00, 1'h0);
    wr(8'h33, 1'h1, "addr rst");
    rd(1'h0, 8'h33, "rd rst");
    cmd(OP_STOP, 8'h00, 1'h0);
    repeat (50) @(posedge mclk);
    final_report();
  end

  initial begin
    #900000;
    failures++;
    $display("[ERR] watchdog expected %s seen %s", "done", "timeout");
    final_report();
  end
endmodule

// file: src/i2c_bus_ctl.sv
// controller end: byte-level command port, makes the bus clock by divider
// assumes a single controller on the bus; no arbitration
`timescale 1ns/1ps
module i2c_bus_ctl
  import i2c_tgt_pkg::*;
(
  input  wire logic                   MCLK_I,
  input  wire logic                   RST_N_I,
  i2c_link_if.ctl                     link,
  input  wire logic                   CMD_VALID_I,
  input  wire i2c_tgt_pkg::op_type    CMD_OP_I,
  input  wire logic [7:0]             CMD_DATA_I,
  input  wire logic                   CMD_ACK_I,
  output logic                        CMD_READY_O,
  output logic                        RSP_VALID_O,
  output logic [7:0]                  RSP_DATA_O,
  output logic                        RSP_ACK_O
);
  import i2c_tgt_pkg::*;

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  ctl_state_type st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] tx_q, tx_d;
  logic [8:0] rx_q, rx_d;
  logic       rd_q, rd_d;
  logic       scl_oe_q, scl_oe_d;
  logic       sda_oe_q, sda_oe_d;
  logic       rdy_d, rsp_v_d, rsp_a_d;
  logic [7:0] rsp_data_d;
  logic       scl_hi;
  logic       take;

  assign scl_hi = scl_s_q[1];
  assign take   = CMD_VALID_I && CMD_READY_O;

  always_comb begin
    st_d = st_q;  cnt_d = cnt_q + 8'h01;  bit_d = bit_q;
    tx_d = tx_q;  rx_d = rx_q;  rd_d = rd_q;
    scl_oe_d = scl_oe_q;  sda_oe_d = sda_oe_q;
    rsp_v_d = 1'b0;  rsp_a_d = RSP_ACK_O;  rsp_data_d = RSP_DATA_O;
    unique case (st_q)
      C_IDLE: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
        if (take && CMD_OP_I == OP_START) begin
          sda_oe_d = 1'b1;
          cnt_d    = 8'h00;
          st_d     = C_START;
        end
      end
      C_START: begin
        if (cnt_q == HIGH_CYC) begin
          scl_oe_d = 1'b1;
          st_d     = C_HOLD;
        end
      end
      C_HOLD: begin
        cnt_d = 8'h00;
        if (take) begin
          unique case (CMD_OP_I)
            OP_START: st_d = C_RS_LOW;
            OP_STOP: begin
              sda_oe_d = 1'b1;
              st_d     = C_SP_LOW;
            end
            OP_WRITE, OP_READ: begin
              rd_d     = (CMD_OP_I == OP_READ);
              tx_d     = (CMD_OP_I == OP_READ) ?
                         {8'hFF, !CMD_ACK_I} : {CMD_DATA_I, 1'b1};
              sda_oe_d = (CMD_OP_I == OP_READ) ? 1'b0 : !CMD_DATA_I[7];
              bit_d    = 4'h0;
              st_d     = C_LOW;
            end
          endcase
        end
      end
      C_LOW: begin
        scl_oe_d = 1'b1;
        sda_oe_d = !tx_q[8];
        if (cnt_q == LOW_CYC) begin
          scl_oe_d = 1'b0;
          cnt_d    = 8'h00;
          st_d     = C_HIGH;
        end
      end
      C_HIGH: begin
        if (!scl_hi) begin
          cnt_d = 8'h00;
        end else if (cnt_q == HIGH_CYC) begin
          rx_d     = {rx_q[7:0], sda_s_q[1]};
          tx_d     = {tx_q[7:0], 1'b1};
          bit_d    = bit_q + 4'h1;
          scl_oe_d = 1'b1;
          cnt_d    = 8'h00;
          st_d     = C_LOW;
          if (bit_q + 4'h1 == BITS_SLOT) begin
            st_d       = C_HOLD;
            rsp_v_d    = 1'b1;
            rsp_data_d = rx_q[7:0];
            rsp_a_d    = rd_q ? !tx_q[8] : !sda_s_q[1];
          end
        end
      end
      C_RS_LOW: begin
        scl_oe_d = 1'b1;
        sda_oe_d = 1'b0;
        if (cnt_q == LOW_CYC) begin
          scl_oe_d = 1'b0;
          cnt_d    = 8'h00;
          st_d     = C_RS_HIGH;
        end
      end
      C_RS_HIGH: begin
        if (!scl_hi) begin
          cnt_d = 8'h00;
        end else if (cnt_q == HIGH_CYC) begin
          sda_oe_d = 1'b1;
          cnt_d    = 8'h00;
          st_d     = C_START;
        end
      end
      C_SP_LOW: begin
        if (cnt_q == LOW_CYC) begin
          scl_oe_d = 1'b0;
          cnt_d    = 8'h00;
          st_d     = C_SP_HIGH;
        end
      end
      C_SP_HIGH: begin
        if (!scl_hi) begin
          cnt_d = 8'h00;
        end else if (cnt_q == HIGH_CYC) begin
          sda_oe_d = 1'b0;
          cnt_d    = 8'h00;
          st_d     = C_SP_BUF;
        end
      end
      C_SP_BUF: begin
        if (cnt_q == BUF_CYC) begin
          st_d = C_IDLE;
        end
      end
    endcase
    rdy_d = (st_d == C_IDLE || st_d == C_HOLD) && !take;
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      scl_s_q <= 2'h3;  sda_s_q <= 2'h3;
      st_q <= C_IDLE;  cnt_q <= 8'h00;  bit_q <= 4'h0;
      tx_q <= 9'h1FF;  rx_q <= 9'h000;  rd_q <= 1'b0;
      scl_oe_q <= 1'b0;  sda_oe_q <= 1'b0;
      CMD_READY_O <= 1'b0;  RSP_VALID_O <= 1'b0;
      RSP_DATA_O <= 8'h00;  RSP_ACK_O <= 1'b0;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      st_q <= st_d;  cnt_q <= cnt_d;  bit_q <= bit_d;
      tx_q <= tx_d;  rx_q <= rx_d;  rd_q <= rd_d;
      scl_oe_q <= scl_oe_d;  sda_oe_q <= sda_oe_d;
      CMD_READY_O <= rdy_d;  RSP_VALID_O <= rsp_v_d;
      RSP_DATA_O <= rsp_data_d;  RSP_ACK_O <= rsp_a_d;
    end
  end

  assign link.ctl_scl_oe = scl_oe_q;
  assign link.ctl_sda_oe = sda_oe_q;
endmodule

// file: src/i2c_link_if.sv
// the two bus lines with open-drain pull-downs from both parties
// assumes pull-ups: a line is high unless some party enables its driver
`timescale 1ns/1ps
interface i2c_link_if;
  logic ctl_scl_oe;
  logic ctl_sda_oe;
  logic dev_scl_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(ctl_scl_oe || dev_scl_oe);
  assign sda = !(ctl_sda_oe || dev_sda_oe);

  modport ctl (output ctl_scl_oe, output ctl_sda_oe, input scl, input sda);
  modport dev (output dev_scl_oe, output dev_sda_oe, input scl, input sda);
endinterface

// file: src/i2c_tgt_dev.sv
// target end: bus engine on the link clock, register access on MCLK_I
// assumes RDATA_I is valid in the MCLK_I cycle in which RD_STB_O is high
// What this block does
// - address 18h with strap low, 19h high
// - address byte: seven address bits, then direction
// - start: data falls while clock high
// - bus busy from start until stop
// - selected only on exact address match
// - ninth clock of each byte is acknowledge
// - sender releases data during acknowledge
// - receiver holds data low through acknowledge high
// - no byte-count limit per transfer
// - target may hold clock low before each read byte it sends; controller waits
// - read stretching at most 1 us
// - stretching only after the read address acknowledge or a controller acknowledge
// - stop: data rises while clock high; bus free
// - controller ends writes with stop
// - controller ends reads with nack, stop
// - repeated start restarts address recognition, stays busy
// - idle bus: both lines released high
// - first write byte loads register pointer
// - read returns previously selected register data
// - burst read advances pointer until nack
// - burst write stores, acknowledges, advances pointer
`timescale 1ns/1ps
module i2c_tgt_dev
  import i2c_tgt_pkg::*;
(
  input  wire logic       MCLK_I,
  input  wire logic       LINK_CLK_I,
  input  wire logic       RST_N_I,
  i2c_link_if.dev         link,
  input  wire logic       ADDR_SELECT_STRAP_I,
  input  wire logic [7:0] RDATA_I,
  output logic            WR_STB_O,
  output logic [7:0]      WR_ADDR_O,
  output logic [7:0]      WR_DATA_O,
  output logic            RD_STB_O,
  output logic [7:0]      RD_ADDR_O,
  output logic            BUSY_O
);
  import i2c_tgt_pkg::*;

  // pin synchronisers and spike filter, link clock
  logic [1:0] line_s1_q;
  logic [1:0] line_s2_q;
  logic [1:0] line_f_q;
  logic [1:0] line_p_q;
  logic       strap_s1_q;
  logic       strap_s2_q;
  logic [1:0] ack_t_s_q;
  logic       ack_t_q;

  always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      line_s1_q  <= 2'h3;
      line_s2_q  <= 2'h3;
      line_p_q   <= 2'h3;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      ack_t_s_q  <= 2'h0;
    end else begin
      line_s1_q  <= {link.sda, link.scl};
      line_s2_q  <= line_s1_q;
      line_p_q   <= line_f_q;
      strap_s1_q <= ADDR_SELECT_STRAP_I;
      strap_s2_q <= strap_s1_q;
      ack_t_s_q  <= {ack_t_s_q[0], ack_t_q};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flt
      logic [1:0] cnt_q;
      logic [1:0] cnt_d;
      logic       f_d;
      always_comb begin
        cnt_d = 2'h0;
        f_d   = line_f_q[gi];
        if (line_s2_q[gi] != line_f_q[gi]) begin
          if (cnt_q == FLT_CYC) begin
            f_d = line_s2_q[gi];
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
      always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          cnt_q        <= 2'h0;
          line_f_q[gi] <= 1'b1;
        end else begin
          cnt_q        <= cnt_d;
          line_f_q[gi] <= f_d;
        end
      end
    end
  endgenerate

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_f    = line_f_q[0];
  assign sda_f    = line_f_q[1];
  assign scl_rise = scl_f && !line_p_q[0];
  assign scl_fall = !scl_f && line_p_q[0];
  assign start_ev = scl_f && line_p_q[0] && line_p_q[1] && !sda_f;
  assign stop_ev  = scl_f && line_p_q[0] && !line_p_q[1] && sda_f;

  // bus engine, link clock
  dev_state_type st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] ptr_q, ptr_d;
  logic [6:0] own_q, own_d;
  logic [4:0] str_q, str_d;
  logic       rw_q, rw_d;
  logic       first_q, first_d;
  logic       cack_q, cack_d;
  logic       scl_oe_q, scl_oe_d;
  logic       sda_oe_q, sda_oe_d;
  logic       busy_q, busy_d;
  logic       want_wr_q, want_wr_d;
  logic       want_rd_q, want_rd_d;
  logic       fetching_q, fetching_d;
  logic       fetched_q, fetched_d;
  logic [7:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  logic       req_t_q, req_t_d;
  logic       xwr_q, xwr_d;
  logic [7:0] xaddr_q, xaddr_d;
  logic [7:0] xdata_q, xdata_d;
  logic [7:0] rdata_q;
  logic       pending;

  assign pending = req_t_q ^ ack_t_s_q[1];

  always_comb begin
    st_d = st_q;  bit_d = bit_q;  sr_d = sr_q;  ptr_d = ptr_q;
    own_d = own_q;  str_d = 5'h0;  rw_d = rw_q;  first_d = first_q;
    cack_d = cack_q;  scl_oe_d = 1'b0;  sda_oe_d = sda_oe_q;
    busy_d = busy_q;  want_wr_d = want_wr_q;  want_rd_d = want_rd_q;
    fetching_d = fetching_q;  fetched_d = fetched_q;
    wa_d = wa_q;  wd_d = wd_q;  req_t_d = req_t_q;
    xwr_d = xwr_q;  xaddr_d = xaddr_q;  xdata_d = xdata_q;
    if (fetching_q && !pending) begin
      fetching_d = 1'b0;
      fetched_d  = 1'b1;
    end
    if (!pending) begin
      if (want_wr_q) begin
        want_wr_d = 1'b0;
        xwr_d     = 1'b1;
        xaddr_d   = wa_q;
        xdata_d   = wd_q;
        req_t_d   = !req_t_q;
      end else if (want_rd_q) begin
        want_rd_d  = 1'b0;
        fetching_d = 1'b1;
        xwr_d      = 1'b0;
        xaddr_d    = ptr_q;
        req_t_d    = !req_t_q;
      end
    end
    if (st_q == D_IDLE) begin
      own_d = strap_s2_q ? OWN_ADDR_HIGH : OWN_ADDR_LOW;
    end
    if (start_ev) begin
      st_d     = D_ADDR;
      bit_d    = 4'h0;
      busy_d   = 1'b1;
      first_d  = 1'b1;
      sda_oe_d = 1'b0;
    end else if (stop_ev) begin
      st_d     = D_IDLE;
      busy_d   = 1'b0;
      sda_oe_d = 1'b0;
    end else begin
      unique case (st_q)
        D_IDLE, D_IGNORE: sda_oe_d = 1'b0;
        D_ADDR, D_RX: begin
          if (scl_rise) begin
            sr_d  = {sr_q[6:0], sda_f};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_BYTE) begin
            if (st_q == D_RX) begin
              sda_oe_d = 1'b1;
              st_d     = D_ACK;
              first_d  = 1'b0;
              want_rd_d = 1'b1;
              fetching_d = 1'b0;
              fetched_d  = 1'b0;
              if (first_q) begin
                ptr_d = sr_q;
              end else begin
                want_wr_d = 1'b1;
                wa_d      = ptr_q;
                wd_d      = sr_q;
                ptr_d     = ptr_q + 8'h01;
              end
            end else if (sr_q[7:1] == own_q) begin
              sda_oe_d = 1'b1;
              rw_d     = sr_q[0];
              st_d     = D_ACK;
            end else begin
              st_d = D_IGNORE;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            bit_d    = 4'h0;
            st_d     = rw_q ? D_LOAD : D_RX;
          end
        end
        D_LOAD: begin
          if (fetched_q || str_q == STRETCH_CYC) begin
            sr_d       = rdata_q;
            sda_oe_d   = !rdata_q[7];
            ptr_d      = ptr_q + 8'h01;
            want_rd_d  = 1'b1;
            fetched_d  = 1'b0;
            fetching_d = 1'b0;
            bit_d      = 4'h0;
            st_d       = D_TX;
          end else begin
            scl_oe_d = 1'b1;
            str_d    = str_q + 5'h01;
            if (!fetching_q && !want_rd_q) begin
              want_rd_d = 1'b1;
            end
          end
        end
        D_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == BITS_BYTE) begin
              sda_oe_d = 1'b0;
              st_d     = D_TXACK;
            end else begin
              sr_d     = {sr_q[6:0], 1'b0};
              sda_oe_d = !sr_q[6];
            end
          end
        end
        D_TXACK: begin
          if (scl_rise) begin
            cack_d = !sda_f;
          end else if (scl_fall) begin
            st_d = cack_q ? D_LOAD : D_IGNORE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= D_IDLE;  bit_q <= 4'h0;  sr_q <= 8'h00;  ptr_q <= 8'h00;
      own_q <= OWN_ADDR_LOW;  str_q <= 5'h00;  rw_q <= 1'b0;
      first_q <= 1'b1;  cack_q <= 1'b0;  scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;  busy_q <= 1'b0;  want_wr_q <= 1'b0;
      want_rd_q <= 1'b0;  fetching_q <= 1'b0;  fetched_q <= 1'b0;
      wa_q <= 8'h00;  wd_q <= 8'h00;  req_t_q <= 1'b0;
      xwr_q <= 1'b0;  xaddr_q <= 8'h00;  xdata_q <= 8'h00;
    end else begin
      st_q <= st_d;  bit_q <= bit_d;  sr_q <= sr_d;  ptr_q <= ptr_d;
      own_q <= own_d;  str_q <= str_d;  rw_q <= rw_d;
      first_q <= first_d;  cack_q <= cack_d;  scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;  busy_q <= busy_d;  want_wr_q <= want_wr_d;
      want_rd_q <= want_rd_d;  fetching_q <= fetching_d;
      fetched_q <= fetched_d;  wa_q <= wa_d;  wd_q <= wd_d;
      req_t_q <= req_t_d;  xwr_q <= xwr_d;  xaddr_q <= xaddr_d;
      xdata_q <= xdata_d;
    end
  end

  assign link.dev_scl_oe = scl_oe_q;
  assign link.dev_sda_oe = sda_oe_q;
  assign BUSY_O          = busy_q;

  // register access side, MCLK_I
  logic [2:0] req_s_q;
  logic       rd_wait_q, rd_wait_d;
  logic       ack_t_d;
  logic [7:0] rdata_d;
  logic       wr_stb_d, rd_stb_d;
  logic [7:0] wr_addr_d, wr_data_d, rd_addr_d;
  logic       req_new;

  assign req_new = req_s_q[1] ^ req_s_q[2];

  always_comb begin
    ack_t_d   = ack_t_q;
    rdata_d   = rdata_q;
    rd_wait_d = 1'b0;
    wr_stb_d  = 1'b0;
    rd_stb_d  = 1'b0;
    wr_addr_d = WR_ADDR_O;
    wr_data_d = WR_DATA_O;
    rd_addr_d = RD_ADDR_O;
    if (rd_wait_q) begin
      rdata_d = RDATA_I;
      ack_t_d = !ack_t_q;
    end else if (req_new) begin
      if (xwr_q) begin
        wr_stb_d  = 1'b1;
        wr_addr_d = xaddr_q;
        wr_data_d = xdata_q;
        ack_t_d   = !ack_t_q;
      end else begin
        rd_stb_d  = 1'b1;
        rd_addr_d = xaddr_q;
        rd_wait_d = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      req_s_q   <= 3'h0;
      rd_wait_q <= 1'b0;
      ack_t_q   <= 1'b0;
      rdata_q   <= 8'h00;
      WR_STB_O  <= 1'b0;
      WR_ADDR_O <= 8'h00;
      WR_DATA_O <= 8'h00;
      RD_STB_O  <= 1'b0;
      RD_ADDR_O <= 8'h00;
    end else begin
      req_s_q   <= {req_s_q[1:0], req_t_q};
      rd_wait_q <= rd_wait_d;
      ack_t_q   <= ack_t_d;
      rdata_q   <= rdata_d;
      WR_STB_O  <= wr_stb_d;
      WR_ADDR_O <= wr_addr_d;
      WR_DATA_O <= wr_data_d;
      RD_STB_O  <= rd_stb_d;
      RD_ADDR_O <= rd_addr_d;
    end
  end
endmodule

// file: src/i2c_tgt_pkg.sv
// shared constants, types and timing for the two-wire target port
// assumes both ends and the bench import this package
package i2c_tgt_pkg;
  localparam logic [6:0] OWN_ADDR_LOW  = 7'h18;
  localparam logic [6:0] OWN_ADDR_HIGH = 7'h19;
  localparam int         MCLK_NS       = 10;
  localparam int         LINK_NS       = 64;
  localparam int         T_SPIKE_NS    = 50;
  localparam int         T_STRETCH_NS  = 1000;
  localparam int         T_LOW_NS      = 1300;
  localparam int         T_HIGH_NS     = 600;
  localparam int         T_BUF_NS      = 1300;
  localparam logic [1:0] FLT_CYC       =
    2'((T_SPIKE_NS + LINK_NS - 1) / LINK_NS);
  localparam logic [4:0] STRETCH_CYC   = 5'(T_STRETCH_NS / LINK_NS);
  localparam logic [7:0] LOW_CYC       =
    8'((T_LOW_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [7:0] HIGH_CYC      =
    8'((T_HIGH_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [7:0] BUF_CYC       =
    8'((T_BUF_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [3:0] BITS_BYTE     = 4'h8;
  localparam logic [3:0] BITS_SLOT     = 4'h9;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_type;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RX, D_ACK, D_LOAD, D_TX,
                            D_TXACK, D_IGNORE} dev_state_type;
  typedef enum logic [3:0] {C_IDLE, C_START, C_HOLD, C_LOW, C_HIGH,
                            C_RS_LOW, C_RS_HIGH, C_SP_LOW, C_SP_HIGH,
                            C_SP_BUF} ctl_state_type;
endpackage
